// file: include/clamp_params.svh
// Register offsets, field positions, reset values and counts of the
// clamp and black-level configuration block.
// Assumes inclusion by bare name from the modules.
`ifndef CLAMP_PARAMS_SVH
`define CLAMP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_INPUT_CLAMP   8'h05
`define OFF_CLAMP_DELAY   8'h06
`define OFF_REF_CONFIG    8'h07
`define OFF_LOOP_CONTROL  8'h08
`define OFF_OFFSET_DAC_0  8'h10
`define OFF_OFFSET_DAC_1  8'h11
`define OFF_OFFSET_DAC_2  8'h12

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_INPUT_CLAMP   8'h00
`define RST_CLAMP_DELAY   8'h27
`define RST_REF_CONFIG    8'h20
`define RST_LOOP_CONTROL  8'h00
`define RST_OFFSET_DAC    8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IC_WIDTH_HI       3
`define IC_WIDTH_LO       2
`define IC_ENABLE         1
`define IC_GATING         0
`define RC_SELECT_HI      5
`define RC_SELECT_LO      4
`define RC_DAC_HI         3
`define RC_DAC_LO         0
`define LC_LINES_HI       7
`define LC_LINES_LO       6
`define LC_PIXELS_HI      5
`define LC_PIXELS_LO      4
`define LC_DIVIDE_HI      3
`define LC_DIVIDE_LO      2
`define LC_MODE_HI        1
`define LC_MODE_LO        0

// ----------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------
`define BASE_PIXELS       6'h04
`define BASE_DIVIDE       7'h08
`define LINES_CODE1       6'h0f
`define LINES_CODE2       6'h1f
`define LINES_CODE3       6'h3f

`endif

// file: include/clamp_pkg.sv
// Types shared by the clamp and black-level configuration block.
// Assumes clamp_params.svh on the include path.
package clamp_pkg;

   // -------------------------------------------------------------------
   // Pulse timer states
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      T_IDLE   = 3'b001,
      T_WAIT   = 3'b010,
      T_ACTIVE = 3'b100
   } timer_state_t;

   typedef enum logic [1:0] {
      BC_OFF   = 2'h0,
      BC_LINE  = 2'h1,
      BC_CLAMP = 2'h2,
      BC_RSVD  = 2'h3
   } black_mode_t;

   // Timing request handed to a pulse timer
   typedef struct packed {
      logic       trigger;
      logic       clear;
      logic [7:0] delay;
      logic [5:0] width;
   } pulse_req_t;

endpackage : clamp_pkg

// file: verilog/pulse_timer.sv
// Delayed pulse of programmable width, counted in pixel clocks.
// Assumes one pixel per clock and trigger/clear as one-cycle levels.
`timescale 1ns/1ps
`include "clamp_params.svh"

module pulse_timer
   import clamp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire pulse_req_t req,
   output logic            pulse
);

   timer_state_t state_reg;
   timer_state_t state_next;
   logic [7:0]   cnt_reg;
   logic [7:0]   cnt_next;
   logic [5:0]   wcnt_reg;
   logic [5:0]   wcnt_next;

   assign pulse = (state_reg == T_ACTIVE);

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      wcnt_next  = wcnt_reg;
      if (req.clear) begin
         state_next = T_IDLE;
      end else if (req.trigger) begin
         state_next = T_WAIT;
         cnt_next   = req.delay;
      end else begin
         case (state_reg)
            T_IDLE: begin
            end
            T_WAIT: begin
               if (cnt_reg == 8'h00) begin
                  state_next = T_ACTIVE;
                  wcnt_next  = req.width - 6'h01;
               end else begin
                  cnt_next = cnt_reg - 8'h01;
               end
            end
            T_ACTIVE: begin
               if (wcnt_reg == 6'h00) begin
                  state_next = T_IDLE;
               end else begin
                  wcnt_next = wcnt_reg - 6'h01;
               end
            end
            default: state_next = T_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= T_IDLE;
         cnt_reg   <= 8'h00;
         wcnt_reg  <= 6'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         wcnt_reg  <= wcnt_next;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   sequence s_quiet;
      !req.trigger && !req.clear;
   endsequence

   sequence s_wait_end;
      ((state_reg == T_WAIT) && (cnt_reg == 8'h00)) and s_quiet;
   endsequence

   a_delay_count: assert property (@(posedge clk)
      disable iff (!rst_n)
      (state_reg == T_WAIT) && (cnt_reg != 8'h00) && !req.trigger
      && !req.clear |=> !pulse && (cnt_reg == $past(cnt_reg) - 8'h01))
      else $error("clamp delay count did not step down");

   a_pulse_start: assert property (@(posedge clk)
      disable iff (!rst_n)
      s_wait_end ##1 s_quiet |-> pulse
      && (wcnt_reg == $past(req.width) - 6'h01))
      else $error("pulse did not start with its width loaded");

   a_pulse_end: assert property (@(posedge clk)
      disable iff (!rst_n)
      pulse && (wcnt_reg == 6'h00) && !req.trigger |=> !pulse)
      else $error("pulse ran past its width");

endmodule : pulse_timer

// file: verilog/line_counter.sv
// Counts line starts for the correction loop and flags when it runs.
// Assumes line_evt is a one-cycle pulse per line.
`timescale 1ns/1ps
`include "clamp_params.svh"

module line_counter
   import clamp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       clear,
   input  wire logic       line_evt,
   input  wire logic [1:0] lines_code,
   output logic [5:0]      count,
   output logic            active
);

   logic [5:0] count_reg;
   logic [5:0] limit;

   assign limit  = (lines_code == 2'h1) ? `LINES_CODE1 :
                   (lines_code == 2'h2) ? `LINES_CODE2 : `LINES_CODE3;
   assign active = (lines_code == 2'h0) || (count_reg < limit);
   assign count  = count_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 6'h00;
      end else if (clear) begin
         count_reg <= 6'h00;
      end else if (line_evt && count_reg != `LINES_CODE3) begin
         count_reg <= count_reg + 6'h01;
      end
   end

   a_line_step: assert property (@(posedge clk)
      disable iff (!rst_n)
      line_evt && !clear && (count_reg < `LINES_CODE3)
      |=> count_reg == $past(count_reg) + 6'h01)
      else $error("line start was not counted");

   a_line_limit: assert property (@(posedge clk)
      disable iff (!rst_n)
      (lines_code == 2'h1) && (count_reg == 6'h0f) |-> !active)
      else $error("loop still running after fifteen lines");

endmodule : line_counter

// file: verilog/clamp_pulse_black_level_config.sv
// Input clamp pulse generator, clamp reference selection and
// black-level correction loop configuration.
// Assumes one pixel per CLK, synchronous inputs, a plain register port.
//
// Operation
// - Clamp pulse width code 00..11 gives 4, 8, 16, 32 pixels.
// - Auto-clamp enable 0 makes no pulse; 1 makes it after line start.
// - Gating bit 1 ANDs pulse with sampling strobe; 0 passes it ungated.
// - Pulse delay after line-start fall from 8-bit register, default 0x27.
// - Source select: 00 external, 01 DAC, 10 ladder (default), 11 reserved.
// - Reference DAC driven from low nibble of reference register.
// - Loop line count: 00 infinite, 01 15, 10 31, 11 63 lines.
// - Any write to loop control clears the loop line counter.
// - Each line-start pulse without a counter clear in the same cycle begins a new counted line, until the count holds at 63.
// - Averaged pixel count: 00..11 give 4, 8, 16, 32 pixels.
// - Offset DAC registers ignore writes while black clamp mode is not 00 (01, 10 or reserved 11).
// - Black clamp mode: 00 off, 01 from line start, 10 from clamp pulse.
`timescale 1ns/1ps
`include "clamp_params.svh"

module clamp_pulse_black_level_config
   import clamp_pkg::*;
#(
   parameter logic [7:0] BLACK_DELAY = 8'h00
)(
   input  wire logic       CLK,
   input  wire logic       RESET_N,
   input  wire logic       SOFT_RESET,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       LINE_START,
   input  wire logic       SAMPLE,
   output logic            INPUT_CLAMP,
   output logic            GATED_CLAMP,
   output logic            BLACK_CLAMP,
   output logic      [1:0] REF_SELECT,
   output logic      [3:0] REF_DAC,
   output logic      [5:0] AVG_PIXELS,
   output logic      [6:0] INTEG_DIVIDE,
   output logic            LOOP_ACTIVE,
   output logic      [7:0] OFFSET_DAC_0,
   output logic      [7:0] OFFSET_DAC_1,
   output logic      [7:0] OFFSET_DAC_2
);

   // -------------------------------------------------------------------
   // Registers and decode
   // -------------------------------------------------------------------
   logic [3:0]  in_clamp_reg;
   logic [7:0]  delay_reg;
   logic [5:0]  ref_reg;
   logic [7:0]  loop_reg;
   logic [7:0]  offset_reg [3];
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   logic        line_prev_reg;
   logic        clamp_prev_reg;
   logic        sel_in_clamp;
   logic        sel_delay;
   logic        sel_ref;
   logic        sel_loop;
   logic [2:0]  sel_offset;
   logic        wr_loop;
   logic        line_fall;
   logic        clamp_fall;
   logic        auto_en;
   logic        gate_en;
   logic [1:0]  width_code;
   black_mode_t black_mode;
   logic        black_on;
   logic        offset_lock;
   logic        in_pulse;
   logic        blk_pulse;
   logic [5:0]  line_count;
   pulse_req_t  in_req;
   pulse_req_t  blk_req;

   assign sel_in_clamp  = (ADDR == `OFF_INPUT_CLAMP);
   assign sel_delay     = (ADDR == `OFF_CLAMP_DELAY);
   assign sel_ref       = (ADDR == `OFF_REF_CONFIG);
   assign sel_loop      = (ADDR == `OFF_LOOP_CONTROL);
   assign sel_offset[0] = (ADDR == `OFF_OFFSET_DAC_0);
   assign sel_offset[1] = (ADDR == `OFF_OFFSET_DAC_1);
   assign sel_offset[2] = (ADDR == `OFF_OFFSET_DAC_2);
   assign wr_loop       = WR && sel_loop;

   assign auto_en    = in_clamp_reg[`IC_ENABLE];
   assign gate_en    = in_clamp_reg[`IC_GATING];
   assign width_code = in_clamp_reg[`IC_WIDTH_HI:`IC_WIDTH_LO];
   assign black_mode = black_mode_t'(loop_reg[`LC_MODE_HI:`LC_MODE_LO]);
   assign black_on   = (black_mode == BC_LINE) || (black_mode == BC_CLAMP);
   assign offset_lock = (black_mode != BC_OFF);

   // -------------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         in_clamp_reg <= 4'(`RST_INPUT_CLAMP);
         delay_reg    <= `RST_CLAMP_DELAY;
         ref_reg      <= 6'(`RST_REF_CONFIG);
         loop_reg     <= `RST_LOOP_CONTROL;
      end else if (SOFT_RESET) begin
         in_clamp_reg <= 4'(`RST_INPUT_CLAMP);
         delay_reg    <= `RST_CLAMP_DELAY;
         ref_reg      <= 6'(`RST_REF_CONFIG);
         loop_reg     <= `RST_LOOP_CONTROL;
      end else if (WR) begin
         if (sel_in_clamp) begin
            in_clamp_reg <= WDATA[3:0];
         end
         if (sel_delay) begin
            delay_reg <= WDATA;
         end
         if (sel_ref) begin
            ref_reg <= WDATA[5:0];
         end
         if (sel_loop) begin
            loop_reg <= WDATA;
         end
      end
   end

   generate
      for (genvar i = 0; i < 3; i++) begin : g_offset
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               offset_reg[i] <= `RST_OFFSET_DAC;
            end else if (SOFT_RESET) begin
               offset_reg[i] <= `RST_OFFSET_DAC;
            end else if (WR && sel_offset[i] && !offset_lock) begin
               offset_reg[i] <= WDATA;
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // Register reads
   // -------------------------------------------------------------------
   always_comb begin
      rdata_next = 8'h00;
      if (sel_in_clamp) begin
         rdata_next = {4'h0, in_clamp_reg};
      end else if (sel_delay) begin
         rdata_next = delay_reg;
      end else if (sel_ref) begin
         rdata_next = {2'h0, ref_reg};
      end else if (sel_loop) begin
         rdata_next = loop_reg;
      end else if (sel_offset[0]) begin
         rdata_next = offset_reg[0];
      end else if (sel_offset[1]) begin
         rdata_next = offset_reg[1];
      end else if (sel_offset[2]) begin
         rdata_next = offset_reg[2];
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= RD ? rdata_next : 8'h00;
      end
   end

   assign RDATA = rdata_reg;

   // -------------------------------------------------------------------
   // Edge detection
   // -------------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         line_prev_reg  <= 1'b0;
         clamp_prev_reg <= 1'b0;
      end else begin
         line_prev_reg  <= LINE_START;
         clamp_prev_reg <= in_pulse;
      end
   end

   assign line_fall  = line_prev_reg && !LINE_START;
   assign clamp_fall = clamp_prev_reg && !in_pulse;

   // -------------------------------------------------------------------
   // Input clamp pulse
   // -------------------------------------------------------------------
   // Enable and trigger
   assign in_req.trigger = auto_en && line_fall;
   assign in_req.clear   = !auto_en || SOFT_RESET;
   assign in_req.delay   = delay_reg;
   assign in_req.width   = `BASE_PIXELS << width_code;

   pulse_timer u_input_timer (
      .clk   (CLK),
      .rst_n (RESET_N),
      .req   (in_req),
      .pulse (in_pulse)
   );

   assign INPUT_CLAMP = in_pulse;
   assign GATED_CLAMP = gate_en ? (in_pulse && SAMPLE) : in_pulse;

   // -------------------------------------------------------------------
   // Black level loop
   // -------------------------------------------------------------------
   // Write clears lines
   line_counter u_line_counter (
      .clk        (CLK),
      .rst_n      (RESET_N),
      .clear      (wr_loop || SOFT_RESET),
      .line_evt   (line_fall),
      .lines_code (loop_reg[`LC_LINES_HI:`LC_LINES_LO]),
      .count      (line_count),
      .active     (LOOP_ACTIVE)
   );

   assign blk_req.trigger = (black_mode == BC_LINE) ? line_fall :
                            (black_mode == BC_CLAMP) ? clamp_fall : 1'b0;
   assign blk_req.clear   = !black_on || !LOOP_ACTIVE || SOFT_RESET;
   assign blk_req.delay   = BLACK_DELAY;
   assign blk_req.width   = AVG_PIXELS;

   pulse_timer u_black_timer (
      .clk   (CLK),
      .rst_n (RESET_N),
      .req   (blk_req),
      .pulse (blk_pulse)
   );

   assign BLACK_CLAMP = blk_pulse;

   // -------------------------------------------------------------------
   // Configuration outputs
   // -------------------------------------------------------------------
   // Reference source
   assign REF_SELECT   = ref_reg[`RC_SELECT_HI:`RC_SELECT_LO];
   assign REF_DAC      = ref_reg[`RC_DAC_HI:`RC_DAC_LO];
   assign AVG_PIXELS   = `BASE_PIXELS << loop_reg[`LC_PIXELS_HI:`LC_PIXELS_LO];
   assign INTEG_DIVIDE = `BASE_DIVIDE << loop_reg[`LC_DIVIDE_HI:`LC_DIVIDE_LO];
   assign OFFSET_DAC_0 = offset_reg[0];
   assign OFFSET_DAC_1 = offset_reg[1];
   assign OFFSET_DAC_2 = offset_reg[2];

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   a_no_clamp_off: assert property (@(posedge CLK)
      disable iff (!RESET_N)
      !auto_en && $past(!auto_en) |-> !INPUT_CLAMP)
      else $error("clamp pulse while auto clamp disabled");

   a_gate_and: assert property (@(posedge CLK)
      disable iff (!RESET_N)
      gate_en |-> GATED_CLAMP == (INPUT_CLAMP && SAMPLE))
      else $error("gated clamp is not pulse and strobe");

   a_delay_read: assert property (@(posedge CLK)
      disable iff (!RESET_N)
      RD && sel_delay |=> RDATA == $past(delay_reg))
      else $error("position register read mismatch");

   a_ref_write: assert property (@(posedge CLK)
      disable iff (!RESET_N)
      WR && sel_ref && !SOFT_RESET |=> REF_DAC == $past(WDATA[3:0])
      && REF_SELECT == $past(WDATA[5:4]))
      else $error("reference fields did not follow write");

   a_line_clear: assert property (@(posedge CLK)
      disable iff (!RESET_N)
      wr_loop |=> line_count == 6'h00)
      else $error("loop write did not clear line counter");

   a_pixel_code: assert property (@(posedge CLK)
      disable iff (!RESET_N)
      loop_reg[`LC_PIXELS_HI:`LC_PIXELS_LO] == 2'h3 |-> AVG_PIXELS == 6'h20)
      else $error("pixel averaging code three is not 32");

   a_divide_code: assert property (@(posedge CLK)
      disable iff (!RESET_N)
      loop_reg[`LC_DIVIDE_HI:`LC_DIVIDE_LO] == 2'h0 |-> INTEG_DIVIDE == 7'h08)
      else $error("integration code zero is not eight");

   a_offset_lock: assert property (@(posedge CLK)
      disable iff (!RESET_N)
      WR && sel_offset[0] && offset_lock && !SOFT_RESET
      |=> OFFSET_DAC_0 == $past(OFFSET_DAC_0))
      else $error("offset register changed while locked");

   a_black_off: assert property (@(posedge CLK)
      disable iff (!RESET_N)
      !black_on && $past(!black_on) |-> !BLACK_CLAMP)
      else $error("black clamp pulse while mode disabled");

endmodule : clamp_pulse_black_level_config

// file: testbench/sensor_timing_model.sv
// Sensor timing model: line-start pulse on request, sampling strobe.
// Assumes go is a one-cycle request driven after a rising clock edge.
`timescale 1ns/1ps

module sensor_timing_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic go,
   output logic      line_start,
   output logic      sample
);
   logic [1:0] hold_reg;
   logic [2:0] phase_reg;

   // -------------------------------------------------------------------
   // Line start held two clocks, strobe pattern free running
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_reg  <= 2'h0;
         phase_reg <= 3'h0;
      end else begin
         hold_reg  <= go ? 2'h2 : hold_reg - {1'b0, hold_reg != 2'h0};
         phase_reg <= phase_reg + 3'h1;
      end
   end
   assign line_start = hold_reg != 2'h0;
   assign sample     = phase_reg[0] ^ phase_reg[2];
endmodule : sensor_timing_model

// file: testbench/test_clamp_pulse_black_level_config.sv
// Self-checking bench of the clamp and black-level configuration block.
// Assumes the sensor timing model drives line start and strobe.
`timescale 1ns/1ps

module test_clamp_pulse_black_level_config;
   import clamp_pkg::*;
   logic       clk, reset_n, soft_reset, wr, rd, go;
   logic [7:0] addr, wdata, rdata, d0, d1, d2, rv, ev;
   logic       line_start, sample, input_clamp, gated_clamp, black_clamp;
   logic       loop_active;
   logic [1:0] ref_select;
   logic [3:0] ref_dac;
   logic [5:0] avg_pixels;
   logic [6:0] integ_divide;
   int         miscompares = 0, checked = 0, seed = 32'hcfca593e;
   int         first, nhi;

   clamp_pulse_black_level_config #(
      .BLACK_DELAY(8'h03)
   ) u_clamp_pulse_black_level_config (
      .CLK(clk), .RESET_N(reset_n), .SOFT_RESET(soft_reset),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .LINE_START(line_start), .SAMPLE(sample),
      .INPUT_CLAMP(input_clamp), .GATED_CLAMP(gated_clamp),
      .BLACK_CLAMP(black_clamp), .REF_SELECT(ref_select),
      .REF_DAC(ref_dac), .AVG_PIXELS(avg_pixels),
      .INTEG_DIVIDE(integ_divide), .LOOP_ACTIVE(loop_active),
      .OFFSET_DAC_0(d0), .OFFSET_DAC_1(d1), .OFFSET_DAC_2(d2));
   sensor_timing_model u_sensor_timing_model (.clk(clk), .rst_n(reset_n),
      .go(go), .line_start(line_start), .sample(sample));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [7:0] rmask(input logic [7:0] a);
      return a == 8'h05 ? 8'h0f : a == 8'h07 ? 8'h3f : 8'hff;
   endfunction : rmask
   function automatic int lim(input int c);
      return (16 << (c - 1)) - 1;
   endfunction : lim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   // Returns just after the edge at which line start falls
   task automatic line;
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : line
   task automatic watch(input int n, input logic gate);
      first = 0; nhi = 0;
      for (int i = 1; i <= n; i++) begin
         @(posedge clk);
         #1 if (input_clamp === 1'b1 && first == 0) first = i;
         nhi += (input_clamp === 1'b1);
         chk(gated_clamp, input_clamp & (sample | !gate));
      end
   endtask : watch
   task automatic results;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   initial begin
      #(60000 * 100);
      miscompares++;
      results;
   end

   initial begin
      reset_n = 1'b0; soft_reset = 1'b0; wr = 1'b0; rd = 1'b0; go = 1'b0;
      addr = 8'h00; wdata = 8'h00;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      // -------------------------------------------------------------------
      // Reset values, unmapped place, soft reset
      // -------------------------------------------------------------------
      chk(ref_select, 8'h02);
      chk(avg_pixels, 8'h04);
      chk(integ_divide, 8'h08);
      wreg(8'hff, 8'h77);
      rreg(8'h06, rv); chk(rv, 8'h27);
      @(posedge clk);
      #1 chk(rdata, 8'h00);
      rreg(8'h07, rv); chk(rv, 8'h20);
      rreg(8'h05, rv); chk(rv, 8'h00);
      rreg(8'h08, rv); chk(rv, 8'h00);
      rreg(8'hff, rv); chk(rv, 8'h00);
      wreg(8'h06, 8'h11);
      rreg(8'h06, rv); chk(rv, 8'h11);
      @(posedge clk) soft_reset <= 1'b1;
      @(posedge clk) soft_reset <= 1'b0;
      rreg(8'h06, rv); chk(rv, 8'h27);
      $display("test reset done");
      // -------------------------------------------------------------------
      // Random register traffic and field decodes
      // -------------------------------------------------------------------
      for (int i = 0; i < 12; i++) begin
         ev = 8'($random(seed));
         wreg(8'h07, ev);
         #1 chk(ref_select, ev[5:4]);
         chk(ref_dac, ev[3:0]);
         rreg(8'h07, rv); chk(rv, ev & rmask(8'h07));
      end
      for (int c = 0; c < 4; c++) begin
         wreg(8'h08, {2'h0, c[1:0], c[1:0], 2'h0});
         #1 chk(avg_pixels, 8'h04 << c);
         chk(integ_divide, 8'h08 << c);
      end
      $display("test registers done");
      // -------------------------------------------------------------------
      // Input clamp delay, width, enable and gating
      // -------------------------------------------------------------------
      for (int k = 0; k < 10; k++) begin
         rv = 8'($random(seed));
         wreg(8'h05, {4'h0, rv[3:2], k != 9, rv[0]});
         wreg(8'h06, k == 0 ? 8'h27 : {4'h0, rv[7:4]});
         line;
         watch((k == 0 ? 8'h27 : rv[7:4]) + (4 << rv[3:2]) + 6, rv[0]);
         chk(nhi, k == 9 ? 0 : 4 << rv[3:2]);
         chk(first, k == 9 ? 0 : (k == 0 ? 8'h27 : rv[7:4]) + 2);
      end
      $display("test clamp done");
      // -------------------------------------------------------------------
      // Loop line count limits and clear on write
      // -------------------------------------------------------------------
      for (int c = 1; c < 4; c++) begin
         wreg(8'h08, {c[1:0], 6'h00});
         repeat (lim(c) - 1) line;
         repeat (3) @(posedge clk);
         chk(loop_active, 1'b1);
         line;
         repeat (3) @(posedge clk);
         chk(loop_active, 1'b0);
         wreg(8'h08, {c[1:0], 6'h00});
         #1 chk(loop_active, 1'b1);
      end
      $display("test lines done");
      // -------------------------------------------------------------------
      // Black clamp modes and offset register lock
      // -------------------------------------------------------------------
      wreg(8'h05, 8'h02);
      wreg(8'h06, 8'h02);
      for (int m = 0; m < 4; m++) begin
         wreg(8'h08, {6'h04, m[1:0]});
         wreg(8'h10, 8'h5a + 8'(m));
         rreg(8'h10, rv); chk(rv, 8'h5a);
         chk(d0, 8'h5a);
         line;
         nhi = 0;
         for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            #1 nhi += (black_clamp === 1'b1);
         end
         chk(nhi, (m == 1 || m == 2) ? 8 : 0);
      end
      wreg(8'h08, 8'h00);
      wreg(8'h11, 8'h33);
      wreg(8'h12, 8'hc4);
      #1 chk(d1, 8'h33);
      chk(d2, 8'hc4);
      $display("test black clamp done");
      results;
   end
endmodule : test_clamp_pulse_black_level_config
